// File: pkg/supervisor_pkg.sv
// constants for the reset and watchdog supervisor
// assumes a 100 MHz system clock and a 1 ms watchdog tick
package supervisor_pkg;

  // clock and timing, times in their own units
  localparam int CLK_NS        = 10;
  localparam int FILTER_NS     = 10000;  // reset_filter_time
  localparam int FILTER_CYC    = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = TICK_NS / CLK_NS;
  localparam int DELAY_FIRST_MS  = 10;   // reset_delay_first
  localparam int DELAY_SECOND_MS = 2;    // reset_delay_second
  localparam int LONG_WIN_MS   = 200;    // long_open_window_time
  localparam int CLOSED_NUM    = 3;      // closed window is 3/5 = 60 % of period
  localparam int CLOSED_DEN    = 5;

  // register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_WD     = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;

  // control register fields
  localparam int CTRL_MODE_LSB     = 0;
  localparam int CTRL_SUPPRESS_BIT = 2;
  localparam int CTRL_DELAY_BIT    = 3;
  localparam int CTRL_THR_LSB      = 4;
  localparam int CTRL_FAILSAFE_BIT = 6;
  localparam int CTRL_SWDEV_BIT    = 7;
  localparam logic [1:0] THR_RESET = 2'h0;

  // mode requests written to the mode field
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_STOP   = 2'h1;
  localparam logic [1:0] REQ_SLEEP  = 2'h2;
  localparam logic [1:0] REQ_SOFT   = 2'h3;

  // watchdog control word fields, all 16 bits even parity
  localparam int WD_TYPE_BIT    = 0;
  localparam int WD_PERIOD_LSB  = 1;
  localparam int WD_STOPOFF_BIT = 4;
  localparam logic [2:0] WD_PERIOD_RESET = 3'h0;

  // status register fields
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_FAIL_LSB  = 3;
  localparam int ST_FERR_BIT  = 5;
  localparam int ST_RST_BIT   = 6;

  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_STOP     = 3'b010,
    MODE_SLEEP    = 3'b011,
    MODE_RESTART  = 3'b100,
    MODE_FAILSAFE = 3'b101
  } mode_t;

  // watchdog periods in 1 ms ticks
  function automatic logic [13:0] period_ticks(input logic [2:0] sel);
    case (sel)
      3'h0:    period_ticks = 14'd10;
      3'h1:    period_ticks = 14'd20;
      3'h2:    period_ticks = 14'd50;
      3'h3:    period_ticks = 14'd100;
      3'h4:    period_ticks = 14'd200;
      3'h5:    period_ticks = 14'd500;
      3'h6:    period_ticks = 14'd1000;
      default: period_ticks = 14'd10000;
    endcase
  endfunction

endpackage

// File: verification/host_model.sv
// host model: serves the supervisor over its register port
// assumes the bench calls its tasks; one access at a time
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic   clk,
  // register port toward the block
  output logic [3:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_write,
  output logic        reg_read
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // top bit used as checksum so the whole word has even parity
  function automatic logic [15:0] even(input logic [15:0] d);
    even = {d[15] ^ (^d), d[14:0]};
  endfunction
  // a write is the service; the soft reset is a mode field of 11
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule // host_model
`default_nettype wire

// File: verification/reset_watchdog_supervisor_bench.sv
// bench for the reset and watchdog supervisor
// assumes a 10-cycle tick so every millisecond figure becomes ten cycles
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_supervisor_bench;
  import supervisor_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        regulator_low;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic        ro;
  logic [1:0]  thr_sel;
  logic [15:0] q[$];
  logic        rd_d = 1'b0;
  logic [1:0]  thr;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  reset_watchdog_supervisor #(.TICK_CYCLES(10)) dut_u (
    .clk(clk), .reset_n(reset_n), .regulator_low(regulator_low), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .supervisor_reset_output_n(ro), .reset_threshold_select(thr_sel));
  host_model host_u (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rdq(input logic [3:0] a, input logic [15:0] e);
    q.push_back(e);
    host_u.rd(a);
  endtask
  task automatic wait_ro(input logic v, input int lim, output int n);
    n = 0;
    while (ro !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("reset_out", ro, v);
  endtask
  task automatic hold_ro(input int n);
    logic b;
    b = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (ro !== 1'b1) b = 1'b1;
    end
    chk("reset_held", b, 1'b0);
  endtask
  // read data is judged in the single cycle it stands; also the hang guard
  always @(posedge clk) begin
    if (rd_d) chk("rdata", reg_rdata, q.pop_front());
    rd_d <= reg_read;
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      errors++;
      summarize;
    end
  end
  initial begin
    reset_n = 1'b0;
    regulator_low = 1'b0;
    thr = 2'($urandom(32'hB434));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    wait_ro(1'b1, 300, t);
    chk("first_delay", 16'(t > 95), 16'h0001);
    rdq(ADDR_STATUS, 16'h0000);
    rdq(ADDR_CTRL, 16'h0000);
    chk("thr", 16'(thr_sel), 16'(THR_RESET));
    $display("test power_up done");
    host_u.wr(ADDR_CTRL, 16'h0000);
    rdq(ADDR_STATUS, 16'h0001);
    host_u.wr(ADDR_WD, host_u.even(16'($urandom) & 16'hFFE0));
    repeat (5) begin
      repeat (60) @(posedge clk);
      host_u.wr(ADDR_WD, host_u.even(16'($urandom) & 16'hFFE0));
    end
    chk("served", ro, 1'b1);
    wait_ro(1'b0, 110, t);
    chk("period", 16'(t >= 90), 16'h0001);
    wait_ro(1'b1, 130, t);
    rdq(ADDR_STATUS, 16'h0009);
    $display("test timeout done");
    host_u.wr(ADDR_WD, host_u.even(16'h0001 | (16'($urandom) & 16'hFFE0)));
    rdq(ADDR_STATUS, 16'h0001);
    repeat (20) @(posedge clk);
    host_u.wr(ADDR_WD, host_u.even(16'h0001));
    wait_ro(1'b0, 10, t);
    wait_ro(1'b1, 130, t);
    rdq(ADDR_STATUS, 16'h0009);
    $display("test window done");
    host_u.wr(ADDR_WD, 16'h8000);
    rdq(ADDR_STATUS, 16'h0029);
    host_u.wr(ADDR_STATUS, 16'h0020);
    rdq(ADDR_STATUS, 16'h0009);
    $display("test parity done");
    host_u.wr(ADDR_CTRL, 16'h0007);
    hold_ro(50);
    rdq(ADDR_STATUS, 16'h0000);
    host_u.wr(ADDR_CTRL, {10'h000, thr, 4'h0});
    rdq(ADDR_CTRL, {10'h000, thr, 4'h0});
    chk("thr", 16'(thr_sel), 16'(thr));
    host_u.wr(ADDR_CTRL, 16'h0003);
    wait_ro(1'b0, 10, t);
    wait_ro(1'b1, 130, t);
    chk("soft_delay", 16'(t >= 90), 16'h0001);
    rdq(ADDR_CTRL, 16'h0000);
    chk("thr", 16'(thr_sel), 16'(THR_RESET));
    host_u.wr(ADDR_CTRL, 16'h0003);
    hold_ro(50);
    rdq(ADDR_STATUS, 16'h0000);
    $display("test soft_reset done");
    host_u.wr(ADDR_CTRL, 16'h0008);
    @(posedge clk);
    regulator_low <= 1'b1;
    wait_ro(1'b0, 1100, t);
    chk("filter", 16'(t >= 990), 16'h0001);
    repeat (200) @(posedge clk);
    regulator_low <= 1'b0;
    wait_ro(1'b1, 40, t);
    chk("second_delay", 16'(t >= 8), 16'h0001);
    $display("test undervoltage done");
    host_u.wr(ADDR_CTRL, 16'h0001);
    rdq(ADDR_STATUS, 16'h0002);
    host_u.wr(ADDR_CTRL, 16'h0080);
    host_u.wr(ADDR_WD, 16'h0000);
    hold_ro(120);
    rdq(ADDR_STATUS, 16'h0009);
    host_u.wr(ADDR_CTRL, 16'h0002);
    rdq(ADDR_STATUS, 16'h0003);
    host_u.wr(ADDR_CTRL, 16'h0040);
    wait_ro(1'b0, 2100, t);
    chk("long_window", 16'(t >= 1990), 16'h0001);
    wait_ro(1'b1, 130, t);
    rdq(ADDR_STATUS, 16'h000D);
    $display("test modes done");
    summarize;
  end
endmodule // reset_watchdog_supervisor_bench
`default_nettype wire

// File: verification/sup_props.sv
// port checker for the reset and watchdog supervisor
// assumes it is bound to reset_watchdog_supervisor and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sup_props
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // inputs of the block
  input wire logic        regulator_low,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  // outputs of the block
  input wire logic [15:0] reg_rdata,
  input wire logic        supervisor_reset_output_n,
  input wire logic [1:0]  reset_threshold_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] uv_cnt;
  logic [15:0] ok_cnt;
  logic        ro;
  logic        ctrl_wr;
  logic [1:0]  wthr;
  assign ro = supervisor_reset_output_n;
  assign ctrl_wr = reg_write && reg_addr == ADDR_CTRL;
  assign wthr = reg_wdata[5:4];
  // run lengths of the comparator level, saturating so they never wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_cnt <= 16'h0000;
      ok_cnt <= 16'h0000;
    end else begin
      uv_cnt <= !regulator_low ? 16'h0000 : (&uv_cnt ? uv_cnt : uv_cnt + 16'h0001);
      ok_cnt <= regulator_low ? 16'h0000 : (&ok_cnt ? ok_cnt : ok_cnt + 16'h0001);
    end
  end
  start_low_a: assert property (!$past(reset_n) |-> !ro)
    else $error("reset output high right after reset");
  uv_filter_a: assert property (uv_cnt == 16'h03F2 |-> !ro)
    else $error("undervoltage did not pull reset low");
  uv_hold_a: assert property (!ro && uv_cnt > 16'h0004 |=> !ro)
    else $error("reset released while undervoltage present");
  rel_delay_a: assert property ($rose(ro) |-> ok_cnt >= 16'(TICK_CYCLES))
    else $error("reset released without delay");
  thr_init_a: assert property (!$past(reset_n) |-> reset_threshold_select == THR_RESET)
    else $error("threshold not default after reset");
  thr_wr_a: assert property (ctrl_wr && reg_wdata[1:0] != REQ_SOFT |=>
    reset_threshold_select == $past(wthr))
    else $error("threshold write not applied");
  ctrl_rd_a: assert property (reg_read && reg_addr == ADDR_CTRL |=> reg_rdata[1:0] == 2'h0)
    else $error("mode request field reads nonzero");
  mode_rd_a: assert property (reg_read && reg_addr == ADDR_STATUS |=> reg_rdata[2:0] <= 3'h5)
    else $error("status mode out of range");
  quiet_soft_a: assert property (ctrl_wr && reg_wdata[1:0] == REQ_SOFT && reg_wdata[2] && ro
    && uv_cnt == 16'h0000 |=> ro [*8])
    else $error("suppressed soft reset pulsed reset");
  cover property ($fell(ro) && regulator_low);
  cover property (ctrl_wr && reg_wdata[1:0] == REQ_SOFT);
  cover property (reg_write && reg_addr == ADDR_WD);
  cover property ($rose(ro));
endmodule // sup_props
bind reset_watchdog_supervisor sup_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .clk(clk), .reset_n(reset_n), .regulator_low(regulator_low), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .supervisor_reset_output_n(supervisor_reset_output_n),
  .reset_threshold_select(reset_threshold_select));
`default_nettype wire

// File: verilog/reset_watchdog_supervisor.sv
// reset output and watchdog supervisor with a plain register port
// assumes undervoltage comparator arrives asynchronously; host serves over the port
//
// Operation
// R1: reset event: filtered low, then delay
// R2: power-up: low until regulator good, first delay
// R3: watchdog failure drives the same reset path
// R4: undervoltage threshold selectable, default after reset
// R5: mode field 11 forces soft reset
// R6: suppress bit decides reset pulse on soft reset
// R7: soft reset ignored outside normal and stop
// R8: type select: time-out default, or window
// R9: watchdog config only written in normal mode
// R10: init: long open window after reset release
// R11: off in sleep/restart, long window in normal
// R12: control write restarts timer with new setting
// R13: valid control write is the trigger
// R14: long window from init, restart, stop exit
// R15: eight periods, common to both types
// R16: failure enters restart or fail-safe, sets flags
// R17: release after failure in restart mode: long window, normal mode
// R18: development mode: missed trigger restarts long window
// R19: fail flags clear on trigger or watchdog off
// R20: time-out: service restarts, expiry resets
// R21: window: early trigger or expiry resets
// R22: parity error ignores write, sets error flag
// R23: timers count millisecond prescaler ticks
// R24: one long window constant everywhere
`timescale 1ns/1ps
`default_nettype none

module reset_watchdog_supervisor #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // regulator comparator, high while below the selected threshold
  input  wire logic        regulator_low,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // supervision outputs
  output logic             supervisor_reset_output_n,
  output logic      [1:0]  reset_threshold_select
);
  import supervisor_pkg::*;

  localparam logic [13:0] LONG_TICKS = 14'(LONG_WIN_MS);
  localparam logic [13:0] DLY1_TICKS = 14'(DELAY_FIRST_MS);
  localparam logic [13:0] DLY2_TICKS = 14'(DELAY_SECOND_MS);
  localparam logic [10:0] FILT_LAST  = 11'(FILTER_CYC - 1);
  localparam logic [16:0] TICK_LAST  = 17'(TICK_CYCLES - 1);

  mode_t       mode_r;
  logic        suppress_r;
  logic        delay_sel_r;
  logic        failsafe_cfg_r;
  logic        swdev_r;
  logic        wd_type_r;
  logic [2:0]  wd_period_r;
  logic        wd_stopoff_r;
  logic        wd_on_r;
  logic        wd_long_r;
  logic [13:0] wd_cnt_r;
  logic [1:0]  fail_flags_r;
  logic        frame_err_r;
  logic        rst_low_r;
  logic [13:0] rst_dly_r;
  logic [16:0] presc_r;
  logic        tick_r;
  logic        uv_meta_r;
  logic        uv_sync_r;
  logic [10:0] uv_filt_r;
  logic        uv_event_r;

  logic        wr_ctrl;
  logic        wr_wd;
  logic        parity_ok;
  logic        soft_rst;
  logic        trig_ok;
  logic        watchdog_fail_flags;
  logic        wd_reset_req;
  logic        rst_release;
  logic        go_normal;
  logic        go_stop;
  logic        go_sleep;
  logic [13:0] period_now;
  logic [13:0] closed_now;
  logic [13:0] limit_now;

  assign wr_ctrl   = reg_write && (reg_addr == ADDR_CTRL);
  assign wr_wd     = reg_write && (reg_addr == ADDR_WD);
  assign parity_ok = ~^reg_wdata;

  // R5 R7
  assign soft_rst = wr_ctrl && (reg_wdata[CTRL_MODE_LSB +: 2] == REQ_SOFT) &&
                    (mode_r == MODE_NORMAL || mode_r == MODE_STOP);

  assign go_normal = wr_ctrl && (reg_wdata[CTRL_MODE_LSB +: 2] == REQ_NORMAL) &&
                     (mode_r == MODE_INIT || mode_r == MODE_STOP ||
                      mode_r == MODE_SLEEP || mode_r == MODE_FAILSAFE);
  assign go_stop   = wr_ctrl && (reg_wdata[CTRL_MODE_LSB +: 2] == REQ_STOP) &&
                     (mode_r == MODE_NORMAL);
  assign go_sleep  = wr_ctrl && (reg_wdata[CTRL_MODE_LSB +: 2] == REQ_SLEEP) &&
                     (mode_r == MODE_NORMAL);

  // trigger counts only when the control word checks out
  assign trig_ok = wr_wd && parity_ok &&
                   (mode_r == MODE_INIT || mode_r == MODE_NORMAL ||
                    mode_r == MODE_STOP);  // R13 R22

  assign period_now = period_ticks(wd_period_r);  // R15
  assign closed_now = 14'((32'(period_now) * CLOSED_NUM) / CLOSED_DEN);
  assign limit_now  = wd_long_r ? LONG_TICKS : period_now;  // R24

  // expiry or a trigger inside the closed window
  assign watchdog_fail_flags = wd_on_r && !soft_rst &&
                   ((tick_r && (wd_cnt_r >= limit_now - 14'd1)) ||  // R20
                    (trig_ok && !wd_long_r && wd_type_r &&
                     (wd_cnt_r < closed_now)));  // R21
  assign wd_reset_req = watchdog_fail_flags && !swdev_r;  // R18

  assign rst_release = rst_low_r && !uv_event_r && tick_r && (rst_dly_r <= 14'd1);

  // millisecond prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_r <= 17'h00000;
      tick_r  <= 1'b0;
    end else if (presc_r >= TICK_LAST) begin
      presc_r <= 17'h00000;
      tick_r  <= 1'b1;  // R23
    end else begin
      presc_r <= presc_r + 17'h00001;
      tick_r  <= 1'b0;
    end
  end

  // comparator synchroniser and filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_meta_r  <= 1'b0;
      uv_sync_r  <= 1'b0;
      uv_filt_r  <= 11'h000;
      uv_event_r <= 1'b0;
    end else begin
      uv_meta_r <= regulator_low;
      uv_sync_r <= uv_meta_r;
      if (!uv_sync_r) begin
        uv_filt_r  <= 11'h000;
        uv_event_r <= 1'b0;
      end else if (uv_filt_r >= FILT_LAST) begin
        uv_event_r <= 1'b1;  // R1
      end else begin
        uv_filt_r <= uv_filt_r + 11'h001;
      end
    end
  end

  // reset output: low from power-up with the first delay loaded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_low_r <= 1'b1;
      rst_dly_r <= DLY1_TICKS;  // R2
    end else if (uv_event_r || wd_reset_req || (soft_rst && !reg_wdata[CTRL_SUPPRESS_BIT] &&
                                                 !suppress_r)) begin
      rst_low_r <= 1'b1;  // R1 R3 R6
      rst_dly_r <= delay_sel_r ? DLY2_TICKS : DLY1_TICKS;
    end else if (rst_release) begin
      rst_low_r <= 1'b0;
    end else if (rst_low_r && tick_r) begin
      rst_dly_r <= rst_dly_r - 14'd1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      supervisor_reset_output_n <= 1'b0;
    end else begin
      supervisor_reset_output_n <= !rst_low_r;
    end
  end

  // control register, soft reset restores defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      suppress_r             <= 1'b0;
      delay_sel_r            <= 1'b0;
      reset_threshold_select <= THR_RESET;  // R4
      failsafe_cfg_r         <= 1'b0;
      swdev_r                <= 1'b0;
    end else if (soft_rst) begin
      suppress_r             <= 1'b0;  // R5
      delay_sel_r            <= 1'b0;
      reset_threshold_select <= THR_RESET;
      failsafe_cfg_r         <= 1'b0;
      swdev_r                <= 1'b0;
    end else if (wr_ctrl) begin
      suppress_r             <= reg_wdata[CTRL_SUPPRESS_BIT];
      delay_sel_r            <= reg_wdata[CTRL_DELAY_BIT];
      reset_threshold_select <= reg_wdata[CTRL_THR_LSB +: 2];  // R4
      failsafe_cfg_r         <= reg_wdata[CTRL_FAILSAFE_BIT];
      swdev_r                <= reg_wdata[CTRL_SWDEV_BIT];
    end
  end

  // device mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_INIT;
    end else begin
      case (mode_r)
        MODE_INIT, MODE_NORMAL, MODE_STOP: begin
          if (soft_rst) begin
            mode_r <= MODE_INIT;  // R5
          end else if (wd_reset_req) begin
            mode_r <= failsafe_cfg_r ? MODE_FAILSAFE : MODE_RESTART;  // R16 R20
          end else if (go_normal) begin
            mode_r <= MODE_NORMAL;
          end else if (go_stop) begin
            mode_r <= MODE_STOP;
          end else if (go_sleep) begin
            mode_r <= MODE_SLEEP;
          end
        end
        MODE_RESTART: begin
          if (rst_release) begin
            mode_r <= MODE_NORMAL;  // R17
          end
        end
        MODE_SLEEP, MODE_FAILSAFE: begin
          if (go_normal) begin
            mode_r <= MODE_NORMAL;
          end
        end
        default: mode_r <= MODE_INIT;
      endcase
    end
  end

  // watchdog configuration, only taken in normal mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_type_r    <= 1'b0;  // R8
      wd_period_r  <= WD_PERIOD_RESET;
      wd_stopoff_r <= 1'b0;
    end else if (soft_rst) begin
      wd_type_r    <= 1'b0;
      wd_period_r  <= WD_PERIOD_RESET;
      wd_stopoff_r <= 1'b0;
    end else if (trig_ok && mode_r == MODE_NORMAL) begin
      wd_type_r    <= reg_wdata[WD_TYPE_BIT];  // R8 R9
      wd_period_r  <= reg_wdata[WD_PERIOD_LSB +: 3];
      wd_stopoff_r <= reg_wdata[WD_STOPOFF_BIT];
    end
  end

  // watchdog timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_on_r   <= 1'b0;
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (soft_rst) begin
      // with the output pulse suppressed no release follows, so start now;
      // the stored bit and the bit in the same word both hold the pulse back
      wd_on_r   <= suppress_r || reg_wdata[CTRL_SUPPRESS_BIT];
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (watchdog_fail_flags) begin
      wd_on_r   <= swdev_r;  // R18
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (rst_release && (mode_r == MODE_INIT || mode_r == MODE_RESTART ||
                                 mode_r == MODE_NORMAL)) begin
      // a brownout in normal mode must not leave the watchdog switched off
      wd_on_r   <= 1'b1;  // R10 R14 R17
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (go_normal && (mode_r != MODE_INIT || !wd_on_r)) begin
      wd_on_r   <= 1'b1;  // R11 R14
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (go_sleep || (go_stop && wd_stopoff_r) || rst_low_r) begin
      wd_on_r   <= 1'b0;  // R11
      wd_cnt_r  <= 14'd0;
    end else if (trig_ok && mode_r == MODE_STOP && !wd_on_r) begin
      wd_on_r   <= 1'b1;  // R14
      wd_long_r <= 1'b1;
      wd_cnt_r  <= 14'd0;
    end else if (trig_ok && wd_on_r) begin
      wd_long_r <= 1'b0;  // R12 R13 R20
      wd_cnt_r  <= 14'd0;
    end else if (wd_on_r && tick_r) begin
      wd_cnt_r  <= wd_cnt_r + 14'd1;
    end
  end

  // failure flags, saturating count of failures
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_flags_r <= 2'h0;
    end else if (soft_rst) begin
      fail_flags_r <= 2'h0;
    end else if (watchdog_fail_flags) begin
      fail_flags_r <= (fail_flags_r == 2'h3) ? 2'h3 : fail_flags_r + 2'h1;  // R16
    end else if ((trig_ok && wd_on_r) || go_sleep || (go_stop && wd_stopoff_r)) begin
      fail_flags_r <= 2'h0;  // R19
    end
  end

  // frame error: a new parity error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_err_r <= 1'b0;
    end else if (wr_wd && !parity_ok) begin
      frame_err_r <= 1'b1;  // R22
    end else if (soft_rst) begin
      frame_err_r <= 1'b0;
    end else if (reg_write && reg_addr == ADDR_STATUS && reg_wdata[ST_FERR_BIT]) begin
      frame_err_r <= 1'b0;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_read) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        ADDR_CTRL:   reg_rdata <= {8'h00, swdev_r, failsafe_cfg_r, reset_threshold_select,
                                   delay_sel_r, suppress_r, 2'h0};
        ADDR_WD:     reg_rdata <= {11'h000, wd_stopoff_r, wd_period_r, wd_type_r};
        ADDR_STATUS: reg_rdata <= {9'h000, rst_low_r, frame_err_r, fail_flags_r, mode_r};
        default:     reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // reset_watchdog_supervisor

`default_nettype wire
